/* hw/conv_pkg.sv */
package conv_pkg;
	// Register indices; the bus byte address is four times the index
	localparam logic [15:0] MODE_IDX = 16'hFFC4;
	localparam logic [15:0] RESULT_IDX = 16'hFFC5;
	localparam logic [15:0] START_IDX = 16'hFFC6;
	localparam logic [15:0] IRQ_STATUS_IDX = 16'hFFC8;
	localparam logic [15:0] IRQ_ENABLE_IDX = 16'hFFC9;
	localparam logic [15:0] IRQ_CLEAR_IDX = 16'hFFCA;
	localparam logic [15:0] EDGE_SEL_IDX = 16'hFFCB;
	localparam int ADDR_W = 18;
	// Reset values
	localparam logic [7:0] MODE_RESET = 8'h30;
	localparam logic [7:0] START_RESET = 8'h7F;
	localparam logic [7:0] MODE_FIXED_ONES = 8'h30;
	localparam logic [7:0] START_FIXED_ONES = 8'h7F;
	// Field positions
	localparam int SPEED_BIT = 7;
	localparam int TRIG_EN_BIT = 6;
	localparam int START_FLAG_BIT = 7;
	localparam int CONV_END_BIT = 0;
	localparam int TRIG_SEEN_BIT = 1;
	localparam int RESULT_W = 8;
	// Conversion periods in system clock cycles
	localparam logic [6:0] PERIOD_SLOW = 7'd62;
	localparam logic [6:0] PERIOD_FAST = 7'd31;
	// Least conversion time the analog part supports, in ns
	localparam int MIN_CONV_NS = 12400;
	localparam int CLK_PERIOD_NS = 4;
	localparam int MIN_CONV_CYCLES = (MIN_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* hw/sar_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_engine (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic abort,
	input wire logic fast,
	input wire logic comp_high,
	output logic busy,
	output logic done,
	output logic [7:0] trial,
	output logic [7:0] result
);
	// Each conversion spends the selected period; bit steps are spread evenly,
	// with the remainder, less two cycles kept after the last decision, spent as settling before the first decision.
	logic [6:0] cnt;
	logic [2:0] bit_idx;
	logic [6:0] period;
	logic [6:0] step_len;

	assign period = fast ? conv_pkg::PERIOD_FAST : conv_pkg::PERIOD_SLOW;
	assign step_len = {3'd0, period[6:3]};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt <= 7'd0;
			bit_idx <= 3'd0;
			trial <= 8'h00;
		end else begin
			done <= 1'b0;
			if (abort) begin
				busy <= 1'b0;
			end else if (start && !busy) begin
				busy <= 1'b1;
				// Flag clear and result load follow done by one cycle, so count two short
				cnt <= period - 7'd2;
				bit_idx <= 3'd7;
				trial <= 8'h80;
			end else if (busy) begin
				if (cnt == 7'd0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt <= cnt - 7'd1;
					// Decide a bit one cycle before its step ends, MSB first, so the LSB
					// is settled before the result is taken
					if (cnt == step_len * {4'd0, bit_idx} + 7'd1) begin
						if (!comp_high) begin
							trial[bit_idx] <= 1'b0;
						end
						if (bit_idx != 3'd0) begin
							trial[bit_idx - 3'd1] <= 1'b1;
							bit_idx <= bit_idx - 3'd1;
						end
					end
				end
			end
		end
	end

	// Taken in the done cycle, together with the start flag clear; a stop then drops it.
	// No reset by intent
	always_ff @(posedge clk) begin
		if (done && !abort) begin
			result <= trial;
		end
	end
endmodule
`default_nettype wire

/* hw/conv_ctrl.sv */
// Summary of operation
// - Convert by successive approximation, producing one 8-bit result per conversion.
// - Load result at completion; hold it until the next conversion completes.
// - Reset never clears or alters the result register.
// - Reset sets mode register to 30 hex: slow, no trigger, no channel.
// - Speed bit 0 gives 62 cycles per conversion, 1 gives 31 cycles.
// - Trigger enable bit 6 allows or blocks pin-started conversions.
// - Enabled trigger edge sets start flag and starts conversion like software.
// - Mode bits 5 and 4 read one and ignore writes.
// - Channel field: 00xx none, 01nn inputs 0-3, 10nn inputs 4-7, 11nn reserved.
// - Start register bits 6..0 read one; reset gives 7F hex.
// - Writing start flag 1 starts; writing 0 stops a running conversion.
// - Start flag reads 1 while converting, clears with result load.
// - Completion sets conversion-end flag; interrupt only when its enable is set.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic [conv_pkg::ADDR_W-1:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic EXT_TRIGGER_PIN,
	input wire logic COMP_HIGH,
	output logic [7:0] TRIAL_CODE,
	output logic SAMPLE_HOLD,
	output logic CHANNEL_VALID,
	output logic [2:0] CHANNEL_NUM,
	output logic IRQ
);
	logic [7:0] conv_mode_reg;
	logic conv_start_flag;
	logic conv_end_request_flag;
	logic trig_seen_flag;
	logic conv_end_irq_enable;
	logic trig_irq_enable;
	logic trigger_edge_sel;
	logic trig_meta;
	logic trig_sync;
	logic trig_prev;
	logic trig_edge;
	logic bus_req;
	logic bus_wr;
	logic lane0_wr;
	logic [15:0] reg_idx;
	logic idx_ok;
	logic [7:0] rd_byte;
	logic sw_start;
	logic sw_stop;
	logic start_conv;
	logic eng_busy;
	logic eng_done;
	logic [7:0] eng_trial;
	logic [7:0] conv_result_reg;
	logic [3:0] input_channel_sel;

	assign input_channel_sel = conv_mode_reg[3:0];
	assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign bus_wr = bus_req && WB_WE_I;
	assign lane0_wr = bus_wr && WB_SEL_I[0];
	// Byte address is four times the register index; all 16 index bits come from address bits 17..2
	assign idx_ok = (WB_ADR_I[1:0] == 2'b00);
	assign reg_idx = WB_ADR_I[conv_pkg::ADDR_W-1:2];

	// Trigger pin crosses in through two flops before the edge detector
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			trig_meta <= 1'b1;
			trig_sync <= 1'b1;
			trig_prev <= 1'b1;
		end else begin
			trig_meta <= EXT_TRIGGER_PIN;
			trig_sync <= trig_meta;
			trig_prev <= trig_sync;
		end
	end

	// Edge select: 0 falling, 1 rising
	assign trig_edge = conv_mode_reg[conv_pkg::TRIG_EN_BIT] &&
		(trigger_edge_sel ? (trig_sync && !trig_prev) : (!trig_sync && trig_prev));

	assign sw_start = lane0_wr && idx_ok && reg_idx == conv_pkg::START_IDX &&
		WB_DAT_I[conv_pkg::START_FLAG_BIT];
	assign sw_stop = lane0_wr && idx_ok && reg_idx == conv_pkg::START_IDX &&
		!WB_DAT_I[conv_pkg::START_FLAG_BIT];
	assign start_conv = (sw_start || trig_edge) && !conv_start_flag;

	// Mode register; bits 5..4 are constant ones
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			conv_mode_reg <= conv_pkg::MODE_RESET;
		end else if (lane0_wr && idx_ok && reg_idx == conv_pkg::MODE_IDX) begin
			conv_mode_reg <= WB_DAT_I[7:0] | conv_pkg::MODE_FIXED_ONES;
		end
	end

	// Start flag: set by software or trigger, cleared by stop or completion
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			conv_start_flag <= 1'b0;
		end else if (sw_stop) begin
			conv_start_flag <= 1'b0;
		end else if (start_conv) begin
			conv_start_flag <= 1'b1;
		end else if (eng_done) begin
			conv_start_flag <= 1'b0;
		end
	end

	// A stop during the last step must not let completion through
	sar_engine u_sar (
		.clk(MCLK),
		.rst_n(RESETN),
		.start(start_conv),
		.abort(sw_stop),
		.fast(conv_mode_reg[conv_pkg::SPEED_BIT]),
		.comp_high(COMP_HIGH),
		.busy(eng_busy),
		.done(eng_done),
		.trial(eng_trial),
		.result(conv_result_reg)
	);

	// Sticky flags; a hardware set wins over a software clear in the same cycle
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			conv_end_request_flag <= 1'b0;
			trig_seen_flag <= 1'b0;
		end else begin
			if (eng_done && !sw_stop) begin
				conv_end_request_flag <= 1'b1;
			end else if (lane0_wr && idx_ok && reg_idx == conv_pkg::IRQ_CLEAR_IDX &&
				WB_DAT_I[conv_pkg::CONV_END_BIT]) begin
				conv_end_request_flag <= 1'b0;
			end
			if (trig_edge) begin
				trig_seen_flag <= 1'b1;
			end else if (lane0_wr && idx_ok && reg_idx == conv_pkg::IRQ_CLEAR_IDX &&
				WB_DAT_I[conv_pkg::TRIG_SEEN_BIT]) begin
				trig_seen_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			conv_end_irq_enable <= 1'b0;
			trig_irq_enable <= 1'b0;
			trigger_edge_sel <= 1'b0;
		end else if (lane0_wr && idx_ok) begin
			if (reg_idx == conv_pkg::IRQ_ENABLE_IDX) begin
				conv_end_irq_enable <= WB_DAT_I[conv_pkg::CONV_END_BIT];
				trig_irq_enable <= WB_DAT_I[conv_pkg::TRIG_SEEN_BIT];
			end
			if (reg_idx == conv_pkg::EDGE_SEL_IDX) begin
				trigger_edge_sel <= WB_DAT_I[0];
			end
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= (conv_end_request_flag && conv_end_irq_enable) ||
				(trig_seen_flag && trig_irq_enable);
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		if (idx_ok) begin
			case (reg_idx)
				conv_pkg::MODE_IDX: rd_byte = conv_mode_reg;
				conv_pkg::RESULT_IDX: rd_byte = conv_result_reg;
				conv_pkg::START_IDX: rd_byte = {conv_start_flag, conv_pkg::START_FIXED_ONES[6:0]};
				conv_pkg::IRQ_STATUS_IDX: rd_byte = {6'h00, trig_seen_flag, conv_end_request_flag};
				conv_pkg::IRQ_ENABLE_IDX: rd_byte = {6'h00, trig_irq_enable, conv_end_irq_enable};
				conv_pkg::EDGE_SEL_IDX: rd_byte = {7'h00, trigger_edge_sel};
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// One wait-free ack per request; unmapped addresses read zero and drop writes
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			WB_ACK_O <= bus_req;
			WB_DAT_O <= bus_req ? {24'h000000, rd_byte} : 32'h00000000;
		end
	end

	// Analog side: channel decode
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			CHANNEL_VALID <= 1'b0;
			CHANNEL_NUM <= 3'd0;
			SAMPLE_HOLD <= 1'b0;
			TRIAL_CODE <= 8'h00;
		end else begin
			CHANNEL_VALID <= input_channel_sel[3] ^ input_channel_sel[2];
			CHANNEL_NUM <= {input_channel_sel[3], input_channel_sel[1:0]};
			SAMPLE_HOLD <= eng_busy;
			TRIAL_CODE <= eng_trial;
		end
	end
endmodule
`default_nettype wire

/* verification/conv_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module conv_monitor (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic [17:0] WB_ADR_I,
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic SAMPLE_HOLD,
	input wire logic IRQ
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	logic rd;
	assign rd = WB_ACK_O && !WB_WE_I && WB_ADR_I[1:0] == 2'h0;
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held too long");
	a_ack_prompt: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack late");
	a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
		else $error("ack without request");
	a_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
		else $error("upper read bits set");
	a_mode_fixed: assert property (
		rd && WB_ADR_I[17:2] == conv_pkg::MODE_IDX |-> WB_DAT_O[5:4] == 2'h3)
		else $error("mode fixed bits wrong");
	a_start_fixed: assert property (
		rd && WB_ADR_I[17:2] == conv_pkg::START_IDX |-> WB_DAT_O[6:0] == 7'h7F)
		else $error("start fixed bits wrong");
	a_hold_min: assert property ($rose(SAMPLE_HOLD) |-> SAMPLE_HOLD[*8])
		else $error("conversion too short");
	a_irq_fall: assert property ($fell(IRQ) |-> $past(WB_ACK_O && WB_WE_I))
		else $error("irq dropped without write");
endmodule
bind conv_ctrl conv_monitor monitor (.MCLK, .RESETN, .WB_ADR_I, .WB_WE_I, .WB_CYC_I,
	.WB_STB_I, .WB_DAT_O, .WB_ACK_O, .SAMPLE_HOLD, .IRQ);
`default_nettype wire

/* verification/comparator_model.sv */
`timescale 1ns/1ps
`default_nettype none
module comparator_model (
	input wire logic [7:0] trial,
	input wire logic [7:0] level,
	output logic comp_high
);
	// Noise-free, so a correct search lands exactly on the level
	// Settles at once: the least conversion time of the analog part is not modelled
	assign comp_high = level >= trial;
endmodule
`default_nettype wire

/* verification/conv_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_tb;
	logic mclk = 0, resetn = 0, we = 0, cyc = 0, stb = 0, pin = 0;
	logic [17:0] adr = 0;
	logic [31:0] dat = 0, rdata;
	logic [7:0] level = 0, last;
	wire logic [31:0] dat_o;
	wire logic ack, comp, chv, irq, hold;
	wire logic [7:0] trial;
	wire logic [2:0] chn;
	int err_total = 0, n_tests = 0, cyc_n = 0, seed = 96402, n;
	always #2 mclk = ~mclk;
	conv_ctrl DUT (.MCLK(mclk), .RESETN(resetn), .WB_ADR_I(adr), .WB_DAT_I(dat),
		.WB_SEL_I(4'h1), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .EXT_TRIGGER_PIN(pin), .COMP_HIGH(comp), .TRIAL_CODE(trial),
		.SAMPLE_HOLD(hold), .CHANNEL_VALID(chv), .CHANNEL_NUM(chn), .IRQ(irq));
	comparator_model model (.trial(trial), .level(level), .comp_high(comp));
	task automatic conclude();
		if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 5000) begin
			err_total++;
			conclude();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] d);
		@(posedge mclk);
		adr <= {idx, 2'h0};
		we <= w;
		dat <= {24'h0, d};
		cyc <= 1'b1;
		stb <= 1'b1;
		@(posedge mclk);
		while (ack !== 1'b1) @(posedge mclk);
		rdata = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] idx, input string what, input logic [31:0] exp);
		bus(idx, 1'b0, 8'h0);
		check(what, rdata, exp);
	endtask
	task automatic convert(input logic fast, input logic trig);
		level <= 8'($random(seed));
		bus(conv_pkg::MODE_IDX, 1'b1, {fast, trig, 6'h05});
		if (trig) pin <= 1'b1;
		else bus(conv_pkg::START_IDX, 1'b1, 8'h80);
		n = 0;
		while (irq !== 1'b1 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		check("irq wait", n < 100, 1);
		if (!trig) check("period", n, fast ? 32 : 63);
		rd(conv_pkg::RESULT_IDX, "result", level);
		rd(conv_pkg::START_IDX, "start", 32'h7F);
		bus(conv_pkg::IRQ_CLEAR_IDX, 1'b1, 8'h03);
		pin <= 1'b0;
		rd(conv_pkg::IRQ_STATUS_IDX, "status", 0);
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		rd(conv_pkg::MODE_IDX, "mode", 32'h30);
		rd(conv_pkg::START_IDX, "start", 32'h7F);
		bus(conv_pkg::MODE_IDX, 1'b1, 8'h0F);
		rd(conv_pkg::MODE_IDX, "mode", 32'h3F);
		rd(16'h0100, "unmapped", 0);
		for (int c = 0; c < 16; c++) begin
			bus(conv_pkg::MODE_IDX, 1'b1, 8'(c));
			@(posedge mclk);
			check("channel", {chv, chn}, {c[3] ^ c[2], c[3], c[1:0]});
		end
		bus(conv_pkg::EDGE_SEL_IDX, 1'b1, 8'h01);
		bus(conv_pkg::IRQ_ENABLE_IDX, 1'b1, 8'h01);
		for (int i = 0; i < 12; i++) convert(i[0], i % 3 == 2);
		// Falling edge selected: a rising pin is ignored, the fall starts a conversion
		level <= 8'($random(seed));
		bus(conv_pkg::EDGE_SEL_IDX, 1'b1, 8'h00);
		bus(conv_pkg::IRQ_ENABLE_IDX, 1'b1, 8'h02);
		pin <= 1'b1;
		repeat (6) @(posedge mclk);
		rd(conv_pkg::START_IDX, "rise ignored", 32'h7F);
		pin <= 1'b0;
		repeat (80) @(posedge mclk);
		check("trigger irq", irq, 1);
		rd(conv_pkg::IRQ_STATUS_IDX, "status", 3);
		rd(conv_pkg::RESULT_IDX, "falling", level);
		bus(conv_pkg::IRQ_CLEAR_IDX, 1'b1, 8'h03);
		bus(conv_pkg::EDGE_SEL_IDX, 1'b1, 8'h01);
		// Trigger pin ignored while the enable bit is clear
		bus(conv_pkg::MODE_IDX, 1'b1, 8'h05);
		pin <= 1'b1;
		repeat (10) @(posedge mclk);
		rd(conv_pkg::START_IDX, "blocked", 32'h7F);
		pin <= 1'b0;
		bus(conv_pkg::IRQ_ENABLE_IDX, 1'b1, 8'h00);
		bus(conv_pkg::START_IDX, 1'b1, 8'h80);
		repeat (70) @(posedge mclk);
		check("masked irq", irq, 0);
		rd(conv_pkg::IRQ_STATUS_IDX, "status", 1);
		bus(conv_pkg::IRQ_CLEAR_IDX, 1'b1, 8'h03);
		last = level;
		level <= ~level;
		bus(conv_pkg::START_IDX, 1'b1, 8'h80);
		repeat (12) @(posedge mclk);
		check("hold", hold, 1);
		bus(conv_pkg::START_IDX, 1'b1, 8'h00);
		repeat (70) @(posedge mclk);
		check("hold", hold, 0);
		rd(conv_pkg::RESULT_IDX, "aborted", last);
		rd(conv_pkg::IRQ_STATUS_IDX, "status", 0);
		resetn <= 1'b0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		rd(conv_pkg::RESULT_IDX, "kept", last);
		rd(conv_pkg::MODE_IDX, "mode", 32'h30);
		conclude();
	end
endmodule
`default_nettype wire
